// file: rtl/uma_bit_timer.sv
// rate tick generator: one pulse every divisor plus one clocks
`timescale 1ns/1ps
module uma_bit_timer #(
  parameter int DIV_W = 16
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic [DIV_W-1:0] divisor_in,
  output logic tick_out
);
  logic [DIV_W-1:0] cnt_q;

  generate
    if (DIV_W < 2) begin : g_bad_width
      $error("divisor width below two");
    end
  endgenerate

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      cnt_q <= '0;
      tick_out <= 1'b0;
    end else if (cnt_q >= divisor_in) begin
      cnt_q <= '0;
      tick_out <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1'b1;
      tick_out <= 1'b0;
    end
  end
endmodule // uma_bit_timer

// file: rtl/uma_pkg.sv
// constants, types and the plain list of behaviours for the serial port with address match
// Function
// - three full-duplex asynchronous modes, independent rates
// - framing check only while framing enable set
// - invalid stop bit sets framing error flag
// - framing error sticky until software or reset
// - with framing check, receive flag on stop
// - given address is address masked by mask
// - all-ones mask means exact address match only; code also accepts the broadcast FF
// - broadcast is address OR mask, zeros ignored
// - ninth received bit loaded into receive field
// - transmit flag at 8th bit or stop start
// - all registers reset to zero, bit access; code gives bit writes to serial_control only
package uma_pkg;

  localparam logic [7:0] SERIAL_CONTROL_ADDR = 8'h98;
  localparam logic [7:0] SERIAL_DATA_BUFFER_ADDR = 8'h99;
  localparam logic [7:0] NODE_ADDRESS_ADDR = 8'hA9;
  localparam logic [7:0] NODE_ADDRESS_MASK_ADDR = 8'hB9;
  localparam logic [7:0] REG_RESET_VALUE = 8'h00;
  localparam logic [7:0] BYTE_ALL_ONES = 8'hFF;

  // receiver oversamples each bit sixteen times and samples in the middle
  localparam logic [3:0] RX_MID_SAMPLE = 4'h7;
  localparam logic [3:0] RX_LAST_BIT_EIGHT = 4'h7;
  localparam logic [3:0] RX_LAST_BIT_NINE = 4'h8;
  localparam logic [2:0] TX_LAST_BIT = 3'h7;

  typedef enum logic [1:0] {
    MODE_SHIFT = 2'b00,
    MODE_8BIT = 2'b01,
    MODE_9BIT_FIXED = 2'b10,
    MODE_9BIT_VAR = 2'b11
  } uma_mode_type;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } uma_rx_state_type;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_START = 3'b001,
    TX_DATA = 3'b010,
    TX_NINTH = 3'b011,
    TX_STOP = 3'b100
  } uma_tx_state_type;

  // serial_control layout, bit 7 down to bit 0
  typedef struct packed {
    logic error_or_mode0;
    logic serial_mode_bit_one;
    logic multiprocessor_enable;
    logic receive_enable;
    logic transmit_ninth_bit;
    logic receive_ninth_bit;
    logic transmit_complete_flag;
    logic receive_complete_flag;
  } uma_serial_control_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic bit_wr;
    logic [2:0] bit_sel;
    logic bit_val;
  } uma_sfr_req_type;

endpackage

// file: rtl/uma_serial_port.sv
// serial port: sfr registers, transmitter, receiver with framing check and address match
`timescale 1ns/1ps
module uma_serial_port #(
  parameter int DIV_W = 16
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire uma_pkg::uma_sfr_req_type sfr_req_in,
  output logic [7:0] sfr_rdata_out,
  input wire logic framing_check_enable_in,
  input wire logic [DIV_W-1:0] tx_divisor_in,
  input wire logic [DIV_W-1:0] rx_divisor_in,
  input wire logic rxd_in,
  output logic txd_out
);
  uma_pkg::uma_serial_control_type serial_control_q;
  logic fe_q;
  logic sm0_q;
  logic [7:0] rx_buf_q;
  logic [7:0] node_addr_q;
  logic [7:0] node_mask_q;
  logic [7:0] serial_control_rd;
  logic [7:0] serial_control_sw;
  logic serial_control_wr;
  logic fce;
  uma_pkg::uma_mode_type mode;

  logic tx_tick;
  logic rx_tick;
  uma_pkg::uma_tx_state_type tx_state_q, tx_state_d;
  logic [7:0] tx_shift_q, tx_shift_d;
  logic [2:0] tx_bit_q, tx_bit_d;
  logic tx_b9_q;
  logic tx_shift_mode_q;
  logic tx_nine_q;
  logic tx_start;
  logic ti_set;
  logic line_d;

  uma_pkg::uma_rx_state_type rx_state_q;
  logic [3:0] rx_cnt_q;
  logic [3:0] rx_bit_q;
  logic [8:0] rx_shift_q;
  logic rx_nine_q;
  logic rx_mid;
  logic last_bit_evt;
  logic stop_evt;
  logic done_evt;
  logic [8:0] frame;
  logic [7:0] rx_byte;
  logic rx_ninth;
  logic given_hit;
  logic bcast_hit;
  logic rx_accept;
  logic fe_set;
  logic [7:0] bcast_addr;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  uma_bit_timer #(.DIV_W(DIV_W)) u_tx_timer (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .divisor_in(tx_divisor_in),
    .tick_out(tx_tick)
  );

  // receive timer runs at sixteen times the bit rate, independent of transmit
  uma_bit_timer #(.DIV_W(DIV_W)) u_rx_timer (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .divisor_in(rx_divisor_in),
    .tick_out(rx_tick)
  );

  assign fce = framing_check_enable_in;
  assign mode = uma_pkg::uma_mode_type'({sm0_q, serial_control_q.serial_mode_bit_one});

  // register access
  always_comb begin
    serial_control_rd = serial_control_q;
    serial_control_rd[7] = fce ? fe_q : sm0_q;
    serial_control_sw = serial_control_rd;
    serial_control_wr = 1'b0;
    if (sfr_req_in.addr == uma_pkg::SERIAL_CONTROL_ADDR) begin
      if (sfr_req_in.wr) begin
        serial_control_sw = sfr_req_in.wdata;
        serial_control_wr = 1'b1;
      end else if (sfr_req_in.bit_wr) begin
        serial_control_sw[sfr_req_in.bit_sel] = sfr_req_in.bit_val;
        serial_control_wr = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      sfr_rdata_out <= uma_pkg::REG_RESET_VALUE;
    end else if (sfr_req_in.rd) begin
      unique case (sfr_req_in.addr)
        uma_pkg::SERIAL_CONTROL_ADDR: sfr_rdata_out <= serial_control_rd;
        uma_pkg::SERIAL_DATA_BUFFER_ADDR: sfr_rdata_out <= rx_buf_q;
        uma_pkg::NODE_ADDRESS_ADDR: sfr_rdata_out <= node_addr_q;
        uma_pkg::NODE_ADDRESS_MASK_ADDR: sfr_rdata_out <= node_mask_q;
        default: sfr_rdata_out <= uma_pkg::REG_RESET_VALUE;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      node_addr_q <= uma_pkg::REG_RESET_VALUE;
      node_mask_q <= uma_pkg::REG_RESET_VALUE;
    end else if (sfr_req_in.wr) begin
      if (sfr_req_in.addr == uma_pkg::NODE_ADDRESS_ADDR) begin
        node_addr_q <= sfr_req_in.wdata;
      end
      if (sfr_req_in.addr == uma_pkg::NODE_ADDRESS_MASK_ADDR) begin
        node_mask_q <= sfr_req_in.wdata;
      end
    end
  end

  // control register: hardware sets win over a software clear in the same cycle
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      serial_control_q <= uma_pkg::REG_RESET_VALUE;
      fe_q <= 1'b0;
      sm0_q <= 1'b0;
    end else begin
      if (serial_control_wr) begin
        serial_control_q[6:3] <= serial_control_sw[6:3];
        if (fce) begin
          fe_q <= serial_control_sw[7] | fe_set;
        end else begin
          sm0_q <= serial_control_sw[7];
        end
      end else if (fe_set) begin
        fe_q <= 1'b1;
      end
      serial_control_q.receive_ninth_bit <= (rx_accept && rx_nine_q) ? rx_ninth
                                  : (serial_control_wr ? serial_control_sw[2] : serial_control_q.receive_ninth_bit);
      serial_control_q.transmit_complete_flag <= ti_set | (serial_control_wr ? serial_control_sw[1]
                                       : serial_control_q.transmit_complete_flag);
      serial_control_q.receive_complete_flag <= rx_accept | (serial_control_wr ? serial_control_sw[0]
                                      : serial_control_q.receive_complete_flag);
    end
  end

  // transmitter; a data-buffer write while busy is ignored
  assign tx_start = sfr_req_in.wr && (sfr_req_in.addr == uma_pkg::SERIAL_DATA_BUFFER_ADDR)
                    && (tx_state_q == uma_pkg::TX_IDLE);

  always_comb begin
    tx_state_d = tx_state_q;
    tx_shift_d = tx_shift_q;
    tx_bit_d = tx_bit_q;
    ti_set = 1'b0;
    unique case (tx_state_q)
      uma_pkg::TX_IDLE: begin
        if (tx_start) begin
          tx_shift_d = sfr_req_in.wdata;
          tx_bit_d = 3'h0;
          tx_state_d = (mode == uma_pkg::MODE_SHIFT) ? uma_pkg::TX_DATA : uma_pkg::TX_START;
        end
      end
      uma_pkg::TX_START: begin
        if (tx_tick) begin
          tx_state_d = uma_pkg::TX_DATA;
        end
      end
      uma_pkg::TX_DATA: begin
        if (tx_tick) begin
          tx_shift_d = {1'b1, tx_shift_q[7:1]};
          tx_bit_d = tx_bit_q + 3'h1;
          if (tx_bit_q == uma_pkg::TX_LAST_BIT) begin
            if (tx_shift_mode_q) begin
              tx_state_d = uma_pkg::TX_IDLE;
              ti_set = 1'b1;
            end else if (tx_nine_q) begin
              tx_state_d = uma_pkg::TX_NINTH;
            end else begin
              tx_state_d = uma_pkg::TX_STOP;
              ti_set = 1'b1;
            end
          end
        end
      end
      uma_pkg::TX_NINTH: begin
        if (tx_tick) begin
          tx_state_d = uma_pkg::TX_STOP;
          ti_set = 1'b1;
        end
      end
      uma_pkg::TX_STOP: begin
        if (tx_tick) begin
          tx_state_d = uma_pkg::TX_IDLE;
        end
      end
      default: tx_state_d = uma_pkg::TX_IDLE;
    endcase
    unique case (tx_state_d)
      uma_pkg::TX_START: line_d = 1'b0;
      uma_pkg::TX_DATA: line_d = tx_shift_d[0];
      uma_pkg::TX_NINTH: line_d = tx_b9_q;
      default: line_d = 1'b1;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      tx_state_q <= uma_pkg::TX_IDLE;
      tx_shift_q <= 8'h00;
      tx_bit_q <= 3'h0;
      txd_out <= 1'b1;
    end else begin
      tx_state_q <= tx_state_d;
      tx_shift_q <= tx_shift_d;
      tx_bit_q <= tx_bit_d;
      txd_out <= line_d;
    end
  end

  // frame shape is caught at start so a mid-frame mode change cannot tear it
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      tx_b9_q <= 1'b0;
      tx_shift_mode_q <= 1'b0;
      tx_nine_q <= 1'b0;
    end else if (tx_start) begin
      tx_b9_q <= serial_control_q.transmit_ninth_bit;
      tx_shift_mode_q <= (mode == uma_pkg::MODE_SHIFT);
      tx_nine_q <= sm0_q;
    end
  end

  // receiver, asynchronous modes only
  assign rx_mid = rx_tick && (rx_cnt_q == uma_pkg::RX_MID_SAMPLE);
  assign last_bit_evt = (rx_state_q == uma_pkg::RX_DATA) && rx_mid
      && (rx_bit_q == (rx_nine_q ? uma_pkg::RX_LAST_BIT_NINE : uma_pkg::RX_LAST_BIT_EIGHT));
  assign stop_evt = (rx_state_q == uma_pkg::RX_STOP) && rx_mid;
  assign done_evt = fce ? stop_evt : last_bit_evt;
  assign frame = fce ? rx_shift_q : {rxd_in, rx_shift_q[8:1]};
  assign rx_byte = rx_nine_q ? frame[7:0] : frame[8:1];
  assign rx_ninth = rx_nine_q & frame[8];
  assign given_hit = ((rx_byte ^ node_addr_q) & node_mask_q) == 8'h00;
  assign bcast_addr = node_addr_q | node_mask_q;
  assign bcast_hit = ((rx_byte ^ bcast_addr) & bcast_addr) == 8'h00;
  assign fe_set = fce && stop_evt && !rxd_in;
  // a frame is lost when the previous one has not been acknowledged
  assign rx_accept = done_evt && !serial_control_q.receive_complete_flag
      && (!serial_control_q.multiprocessor_enable
          || (rx_nine_q ? (rx_ninth && (given_hit || bcast_hit)) : (!fce || rxd_in)));

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      rx_state_q <= uma_pkg::RX_IDLE;
      rx_cnt_q <= 4'h0;
      rx_bit_q <= 4'h0;
      rx_shift_q <= 9'h000;
      rx_nine_q <= 1'b0;
    end else begin
      if (rx_state_q != uma_pkg::RX_IDLE && rx_tick) begin
        rx_cnt_q <= rx_cnt_q + 4'h1;
      end
      unique case (rx_state_q)
        uma_pkg::RX_IDLE: begin
          if (serial_control_q.receive_enable && mode != uma_pkg::MODE_SHIFT && !rxd_in) begin
            rx_state_q <= uma_pkg::RX_START;
            rx_cnt_q <= 4'h0;
            rx_nine_q <= sm0_q;
          end
        end
        uma_pkg::RX_START: begin
          if (rx_mid) begin
            rx_bit_q <= 4'h0;
            rx_state_q <= rxd_in ? uma_pkg::RX_IDLE : uma_pkg::RX_DATA;
          end
        end
        uma_pkg::RX_DATA: begin
          if (rx_mid) begin
            rx_shift_q <= {rxd_in, rx_shift_q[8:1]};
            rx_bit_q <= rx_bit_q + 4'h1;
            if (last_bit_evt) begin
              rx_state_q <= uma_pkg::RX_STOP;
            end
          end
        end
        uma_pkg::RX_STOP: begin
          if (rx_mid) begin
            rx_state_q <= uma_pkg::RX_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      rx_buf_q <= uma_pkg::REG_RESET_VALUE;
    end else if (rx_accept) begin
      rx_buf_q <= rx_byte;
    end
  end

  a_fe_sticky: assert property (fe_q && !(serial_control_wr && fce && !serial_control_sw[7]) |=> fe_q)
    else $error("framing error flag dropped without clear");
  // a software write of one to the flag is a legal set, so only hardware sets are traced
  a_fe_cause: assert property ($rose(fe_q) && !$past(serial_control_wr && serial_control_sw[7])
      |-> $past(fce && stop_evt && !rxd_in))
    else $error("framing error set without a bad stop bit");
  a_fe_gated: assert property (!fce && !fe_q |=> !fe_q)
    else $error("framing error set while check disabled");
  a_ri_on_stop: assert property ($rose(serial_control_q.receive_complete_flag) && $past(fce)
      && $past(rx_accept)
      |-> $past(rx_state_q) == uma_pkg::RX_STOP)
    else $error("receive flag not raised on stop bit");
  a_ti_at_stop: assert property ($rose(serial_control_q.transmit_complete_flag) && !tx_shift_mode_q
      && $past(ti_set)
      |-> tx_state_q == uma_pkg::TX_STOP && txd_out)
    else $error("transmit flag not at stop start");
  a_ninth_load: assert property (rx_accept && rx_nine_q |=> serial_control_q.receive_ninth_bit
      == $past(rx_ninth))
    else $error("ninth bit not loaded");
  a_addr_filter: assert property (done_evt && rx_nine_q && serial_control_q.multiprocessor_enable
      && !(rx_ninth && (given_hit || bcast_hit)) |-> !rx_accept)
    else $error("unmatched address frame accepted");
  a_exact_mask: assert property (rx_accept && rx_nine_q && serial_control_q.multiprocessor_enable
      && node_mask_q == uma_pkg::BYTE_ALL_ONES
      |-> rx_byte == node_addr_q || rx_byte == uma_pkg::BYTE_ALL_ONES)
    else $error("all-ones mask accepted a non-exact address");
  a_bit7_view: assert property (sfr_req_in.rd && sfr_req_in.addr == uma_pkg::SERIAL_CONTROL_ADDR
      |=> sfr_rdata_out[7] == ($past(fce) ? $past(fe_q) : $past(sm0_q)))
    else $error("control bit seven shows wrong source");
  a_reset_clear: assert property (@(posedge mclk_in) disable iff (1'b0)
      $past(reset_in) |-> serial_control_q == 8'h00 && rx_buf_q == 8'h00 && node_mask_q == 8'h00)
    else $error("registers not cleared by reset");
  a_duplex_idle: assert property (tx_state_q == uma_pkg::TX_IDLE |-> txd_out)
    else $error("line not idle high");
endmodule // uma_serial_port

// file: testbench/uma_remote_node.sv
// remote serial node: drives frames onto the receive line and decodes the transmit line
`timescale 1ns/1ps
module uma_remote_node #(
  parameter int RX_BIT = 16,
  parameter int TX_BIT = 4
) (
  input wire logic mclk_in,
  input wire logic txd_in,
  output logic rxd_out,
  output logic [8:0] got_out
);
  initial rxd_out = 1'b1;

  // one frame, lsb first; nine adds the ninth slot, stp low gives a broken stop bit
  task automatic send(input logic [7:0] d, input logic b9, input logic nine, input logic stp);
    logic [10:0] f;
    int n;
    f = {stp, b9, d, 1'b0};
    n = nine ? 11 : 10;
    if (!nine) begin
      f[9] = stp;
    end
    for (int i = 0; i < n; i++) begin
      @(posedge mclk_in) rxd_out <= f[i];
      repeat (RX_BIT - 1) @(posedge mclk_in);
    end
    @(posedge mclk_in) rxd_out <= 1'b1;
  endtask

  // the first tick edge is only visible when bit 0 is high, so test bytes keep it set
  initial begin
    got_out = 9'h000;
    forever begin
      @(negedge txd_in);
      @(posedge txd_in);
      repeat (TX_BIT / 2) @(posedge mclk_in);
      for (int i = 0; i < 9; i++) begin
        got_out[i] = txd_in;
        repeat (TX_BIT) @(posedge mclk_in);
      end
    end
  end
endmodule // uma_remote_node

// file: testbench/uma_serial_port_bench.sv
// self-checking testbench for the serial port with address match
`timescale 1ns/1ps
module uma_serial_port_bench;
  localparam int RXB = 16;
  localparam int TXB = 4;
  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] mask;
    logic [7:0] data;
    logic b9;
    logic ok;
  } uma_row_type;
  logic mclk_in;
  logic reset_in;
  logic fce;
  logic rxd;
  logic txd;
  logic [7:0] rdata;
  logic [8:0] got;
  uma_pkg::uma_sfr_req_type req;
  int n_errors = 0;
  int n_tests = 0;
  uma_row_type rows [7] = '{
    '{8'hB0, 8'hFC, 8'h57, 1'b1, 1'b1},
    '{8'hB0, 8'hFC, 8'h5A, 1'b1, 1'b0},
    '{8'hB0, 8'hFC, 8'hFF, 1'b1, 1'b1},
    '{8'hB0, 8'hFC, 8'h56, 1'b0, 1'b0},
    '{8'hB0, 8'hFF, 8'h57, 1'b1, 1'b0},
    '{8'hB0, 8'hFF, 8'h56, 1'b1, 1'b1},
    '{8'hD0, 8'hFF, 8'h12, 1'b0, 1'b1}
  };
  logic [7:0] tctl [2] = '{8'h50, 8'hD0};
  logic [8:0] texp [2] = '{9'h13D, 9'h0C5};

  uma_serial_port #(.DIV_W(16)) i_dut (.mclk_in(mclk_in), .reset_in(reset_in),
    .sfr_req_in(req), .sfr_rdata_out(rdata), .framing_check_enable_in(fce),
    .tx_divisor_in(16'h0003), .rx_divisor_in(16'h0000), .rxd_in(rxd), .txd_out(txd));
  uma_remote_node #(.RX_BIT(RXB), .TX_BIT(TXB)) i_node (.mclk_in(mclk_in), .txd_in(txd),
    .rxd_out(rxd), .got_out(got));

  initial begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
  end

  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] seen);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one request cycle; read data has landed when the task returns
  task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w, input logic b,
                     input logic [2:0] s);
    @(posedge mclk_in);
    req <= '{addr: a, wdata: d, wr: w, rd: !w && !b, bit_wr: b, bit_sel: s, bit_val: d[0]};
    @(posedge mclk_in);
    req <= '0;
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(a, d, 1'b1, 1'b0, 3'h0);
  endtask

  task automatic bw(input logic [2:0] s, input logic v);
    acc(8'h98, {7'h00, v}, 1'b0, 1'b1, s);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    acc(a, 8'h00, 1'b0, 1'b0, 3'h0);
    chk(what, {1'b0, exp}, {1'b0, rdata});
  endtask

  task automatic wait_flag(input int b);
    for (int i = 0; i < 400; i++) begin
      acc(8'h98, 8'h00, 1'b0, 1'b0, 3'h0);
      if (rdata[b] === 1'b1) break;
    end
  endtask

  task automatic test_done();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk_in);
    n_errors++;
    test_done();
  end

  initial begin
    req = '0;
    fce = 1'b0;
    reset_in = 1'b1;
    repeat (10) @(posedge mclk_in);
    reset_in <= 1'b0;
    rd(8'h98, 8'h00, "control reset");
    rd(8'h99, 8'h00, "data buffer reset");
    rd(8'hA9, 8'h00, "node address reset");
    rd(8'hB9, 8'h00, "mask reset");
    wr(8'h10, 8'hAA);
    rd(8'h10, 8'h00, "unmapped read");
    $display("test reset done");
    wr(8'hA9, 8'h56);
    for (int i = 0; i < 7; i++) begin
      wr(8'h98, rows[i].ctl);
      wr(8'hB9, rows[i].mask);
      i_node.send(rows[i].data, rows[i].b9, 1'b1, 1'b1);
      repeat (4) @(posedge mclk_in);
      rd(8'h98, {rows[i].ctl[7:3], rows[i].ok & rows[i].b9, 1'b0, rows[i].ok}, "match flags");
      if (rows[i].ok) begin
        rd(8'h99, rows[i].data, "matched byte");
      end
    end
    $display("test address match done");
    // mode 1 with a broken stop bit, framing check off then on
    wr(8'h98, 8'h50);
    i_node.send(8'hA5, 1'b0, 1'b0, 1'b0);
    repeat (4) @(posedge mclk_in);
    rd(8'h98, 8'h51, "no framing check");
    rd(8'h99, 8'hA5, "mode 1 byte");
    bw(3'h0, 1'b0);
    @(posedge mclk_in);
    fce <= 1'b1;
    i_node.send(8'h3C, 1'b0, 1'b0, 1'b0);
    repeat (4) @(posedge mclk_in);
    rd(8'h98, 8'hD1, "framing error set");
    bw(3'h0, 1'b0);
    fork
      i_node.send(8'h5B, 1'b0, 1'b0, 1'b1);
      begin
        repeat (145) @(posedge mclk_in);
        rd(8'h98, 8'hD0, "receive flag before stop");
      end
    join
    repeat (4) @(posedge mclk_in);
    rd(8'h98, 8'hD1, "framing error kept");
    rd(8'h99, 8'h5B, "byte after good stop");
    bw(3'h7, 1'b0);
    rd(8'h98, 8'h51, "framing error cleared");
    @(posedge mclk_in);
    fce <= 1'b0;
    $display("test framing done");
    for (int i = 0; i < 2; i++) begin
      wr(8'h98, tctl[i]);
      wr(8'h99, texp[i][7:0]);
      wait_flag(1);
      chk("line at transmit flag", 9'h001, 9'(txd));
      chk("bits before transmit flag", {1'b0, texp[i][7:0]}, {1'b0, got[7:0]});
      repeat (3 * TXB) @(posedge mclk_in);
      chk("transmitted frame", texp[i], got);
    end
    // shift mode: data only on the line, flag at the end of the eighth bit time
    wr(8'h98, 8'h00);
    wr(8'h99, 8'hFF);
    wait_flag(1);
    chk("mode 0 transmit flag", 9'h001, {8'h00, rdata[1]});
    chk("mode 0 line at flag", 9'h001, 9'(txd));
    $display("test transmit done");
    test_done();
  end
endmodule // uma_serial_port_bench
